// ===== common/ccr_pkg.sv
// Package of constants and types for the core register set.
package ccr_pkg;
  // ============================================================
  // Flag bit positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_NEG = 2;
  localparam int FLAG_PRIO_LO = 3;
  localparam int FLAG_HALF = 4;
  localparam int FLAG_PRIO_HI = 5;
  // ============================================================
  // Reset values and fixed bits
  localparam logic [7:0] FLAGS_RESET = 8'he8;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'hc0;
  localparam logic [15:0] STACK_TOP = 16'h01ff;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // ============================================================
  // Register selector for load and store transfers
  typedef enum logic [2:0] {
    CCR_SEL_ACC = 3'b000,
    CCR_SEL_IDX_X = 3'b001,
    CCR_SEL_IDX_Y = 3'b010,
    CCR_SEL_PC_LOW = 3'b011,
    CCR_SEL_PC_HIGH = 3'b100,
    CCR_SEL_FLAGS = 3'b101,
    CCR_SEL_STACK_LOW = 3'b110,
    CCR_SEL_NONE = 3'b111
  } ccr_sel_t;
  // Flag-producing operation classes
  typedef enum logic [2:0] {
    CCR_OP_NONE = 3'b000,
    CCR_OP_ADD = 3'b001,
    CCR_OP_ADC = 3'b010,
    CCR_OP_ARITH = 3'b011,
    CCR_OP_LOGIC = 3'b100,
    CCR_OP_SHIFT = 3'b101
  } ccr_op_t;
  // Stack operations
  typedef enum logic [1:0] {
    CCR_STK_IDLE = 2'b00,
    CCR_STK_PUSH = 2'b01,
    CCR_STK_POP = 2'b10,
    CCR_STK_RESET = 2'b11
  } ccr_stk_t;
  // Bytes consumed by a call and by an interrupt context save.
  localparam logic [2:0] CALL_BYTES = 3'h2;
  localparam logic [2:0] INT_CTX_BYTES = 3'h5;
endpackage : ccr_pkg

// ===== rtl/ccr_core_regs.sv
// Programmer register set of the 8-bit core: accumulator, index, PC, flags, stack.
`timescale 1ns/100ps
`default_nettype none
module ccr_core_regs
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register load and store
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_sel,
  output logic [7:0] rd_data,
  // ALU result and flag update
  input wire logic [2:0] alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic alu_wr_acc,
  input wire logic shift_carry,
  input wire logic set_carry_instr,
  input wire logic clear_carry_instr,
  // Interrupt mask control
  input wire logic int_entry,
  input wire logic [1:0] int_priority_regs,
  input wire logic mask_wr,
  input wire logic [1:0] mask_wr_val,
  // Program counter
  input wire logic pc_load,
  input wire logic [15:0] pc_next_in,
  // Stack control
  input wire logic [1:0] stk_op,
  input wire logic [7:0] push_data,
  output logic [7:0] pop_data,
  output logic [7:0] stk_wr_data,
  // Stack memory strobe and address
  output logic stk_wr,
  output logic [15:0] stk_addr,
  // State views
  output logic [7:0] acc_q,
  output logic [7:0] idx_x_q,
  output logic [7:0] idx_y_q,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags,
  output logic [15:0] stack_pointer
);
  // ============================================================
  // Arithmetic
  logic [8:0] sum_full;
  logic [4:0] sum_half;
  logic [7:0] alu_res;
  logic cin;
  logic flag_op;
  logic [7:0] stack_low_reg;
  logic [7:0] stack_low_next;
  logic [7:0] flags_reg;
  logic [7:0] stack_mem [0:255];

  assign cin = (alu_op == CCR_OP_ADC) ? flags_reg[FLAG_CARRY] : 1'b0;
  assign sum_full = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, cin};
  assign sum_half = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
  assign alu_res = (alu_op == CCR_OP_LOGIC || alu_op == CCR_OP_SHIFT) ? alu_a : sum_full[7:0];
  assign flag_op = (alu_op != CCR_OP_NONE);

  // ============================================================
  // Accumulator and index registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ACC_RESET;
    end else if (alu_wr_acc && flag_op) begin
      acc_q <= alu_res;
    end else if (wr_en && wr_sel == CCR_SEL_ACC) begin
      acc_q <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx_x_q <= IDX_RESET;
    end else if (wr_en && wr_sel == CCR_SEL_IDX_X) begin
      idx_x_q <= wr_data;
    end
  end

  // Interrupt entry and return never touch this register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx_y_q <= IDX_RESET;
    end else if (wr_en && wr_sel == CCR_SEL_IDX_Y) begin
      idx_y_q <= wr_data;
    end
  end

  // ============================================================
  // Program counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_counter <= PC_RESET;
    end else if (pc_load) begin
      program_counter <= pc_next_in;
    end else if (wr_en && wr_sel == CCR_SEL_PC_LOW) begin
      program_counter[7:0] <= wr_data;
    end else if (wr_en && wr_sel == CCR_SEL_PC_HIGH) begin
      program_counter[15:8] <= wr_data;
    end
  end

  // ============================================================
  // Condition flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      if (stk_op == CCR_STK_POP && wr_sel == CCR_SEL_FLAGS) begin
        flags_reg <= stack_mem[stack_low_next] | FLAGS_FIXED_ONES;
      end else if (wr_en && wr_sel == CCR_SEL_FLAGS) begin
        flags_reg <= wr_data | FLAGS_FIXED_ONES;
      end else begin
        if (alu_op == CCR_OP_ADD || alu_op == CCR_OP_ADC) begin
          flags_reg[FLAG_HALF] <= sum_half[4];
        end
        if (flag_op) begin
          flags_reg[FLAG_NEG] <= alu_res[7];
          flags_reg[FLAG_ZERO] <= (alu_res == 8'h00);
        end
        if (set_carry_instr) begin
          flags_reg[FLAG_CARRY] <= 1'b1;
        end else if (clear_carry_instr) begin
          flags_reg[FLAG_CARRY] <= 1'b0;
        end else if (alu_op == CCR_OP_SHIFT) begin
          flags_reg[FLAG_CARRY] <= shift_carry;
        end else if (alu_op == CCR_OP_ADD || alu_op == CCR_OP_ADC ||
                     alu_op == CCR_OP_ARITH) begin
          flags_reg[FLAG_CARRY] <= sum_full[8];
        end
        // Hardware entry takes priority over a software mask write.
        if (int_entry) begin
          flags_reg[FLAG_PRIO_HI] <= int_priority_regs[1];
          flags_reg[FLAG_PRIO_LO] <= int_priority_regs[0];
        end else if (mask_wr) begin
          flags_reg[FLAG_PRIO_HI] <= mask_wr_val[1];
          flags_reg[FLAG_PRIO_LO] <= mask_wr_val[0];
        end
      end
    end
  end
  assign condition_flags = flags_reg;

  // ============================================================
  // Stack pointer and stack memory
  always_comb begin
    stack_low_next = stack_low_reg;
    case (stk_op)
      CCR_STK_PUSH: stack_low_next = stack_low_reg - 8'h01;
      CCR_STK_POP: stack_low_next = stack_low_reg + 8'h01;
      CCR_STK_RESET: stack_low_next = STACK_TOP[7:0];
      default: stack_low_next = stack_low_reg;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stack_low_reg <= STACK_TOP[7:0];
    end else if (stk_op != CCR_STK_IDLE) begin
      stack_low_reg <= stack_low_next;
    end else if (wr_en && wr_sel == CCR_SEL_STACK_LOW) begin
      stack_low_reg <= wr_data;
    end
  end
  assign stack_pointer = {STACK_PAGE, stack_low_reg};

  // Push writes at the pointer, then it moves down; a push on interrupt entry
  // must start with the PC low byte, which the sequencer feeds first.
  always_ff @(posedge clk_sys) begin
    if (stk_op == CCR_STK_PUSH) begin
      stack_mem[stack_low_reg] <= push_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pop_data <= 8'h00;
      stk_wr <= 1'b0;
      stk_wr_data <= 8'h00;
      stk_addr <= STACK_TOP;
    end else begin
      stk_wr <= (stk_op == CCR_STK_PUSH);
      stk_wr_data <= push_data;
      stk_addr <= {STACK_PAGE, stack_low_reg};
      if (stk_op == CCR_STK_POP) begin
        pop_data <= stack_mem[stack_low_next];
      end
    end
  end

  // ============================================================
  // Read port: registers are not memory mapped.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_sel == CCR_SEL_ACC) begin
      rd_data <= acc_q;
    end else if (rd_sel == CCR_SEL_IDX_X) begin
      rd_data <= idx_x_q;
    end else if (rd_sel == CCR_SEL_IDX_Y) begin
      rd_data <= idx_y_q;
    end else if (rd_sel == CCR_SEL_PC_LOW) begin
      rd_data <= program_counter[7:0];
    end else if (rd_sel == CCR_SEL_PC_HIGH) begin
      rd_data <= program_counter[15:8];
    end else if (rd_sel == CCR_SEL_FLAGS) begin
      rd_data <= flags_reg;
    end else if (rd_sel == CCR_SEL_STACK_LOW) begin
      rd_data <= stack_low_reg;
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ============================================================
  // Checks
  a_flags_top_ones: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flags_reg[7:6] == 2'b11) else $error("flag bits 7:6 not one");
  a_stack_page_fix: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stack_pointer[15:8] == STACK_PAGE && stk_addr[15:8] == STACK_PAGE)
    else $error("stack page moved");
  a_push_dec: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stk_op == CCR_STK_PUSH |=> stack_low_reg == $past(stack_low_reg) - 8'h01)
    else $error("push did not decrement");
  a_pop_inc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stk_op == CCR_STK_POP |=> stack_low_reg == $past(stack_low_reg) + 8'h01)
    else $error("pop did not increment");
  a_rsp_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stk_op == CCR_STK_RESET |=> stack_pointer == STACK_TOP)
    else $error("stack reset wrong");
  a_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flag_op && !(stk_op == CCR_STK_POP && wr_sel == CCR_SEL_FLAGS) &&
     !(wr_en && wr_sel == CCR_SEL_FLAGS)) |=> flags_reg[1] == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flag_op && !(stk_op == CCR_STK_POP && wr_sel == CCR_SEL_FLAGS) &&
     !(wr_en && wr_sel == CCR_SEL_FLAGS)) |=> flags_reg[2] == $past(alu_res[7]))
    else $error("negative flag wrong");
  a_int_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (int_entry && stk_op != CCR_STK_POP && !(wr_en && wr_sel == CCR_SEL_FLAGS))
    |=> {flags_reg[5], flags_reg[3]} == $past(int_priority_regs))
    else $error("mask not loaded");
  a_y_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(wr_en && wr_sel == CCR_SEL_IDX_Y) |=> $stable(idx_y_q))
    else $error("second index changed");
endmodule : ccr_core_regs
`default_nettype wire

// ===== testbench/ccr_tb.sv
// Self-checking bench for the core register set.
`timescale 1ns/100ps
`default_nettype none
module tb
  import ccr_pkg::*;
();
  // ============================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic wr_en = 1'b0, alu_wr_acc = 1'b0, shift_carry = 1'b0;
  logic set_carry_instr = 1'b0, clear_carry_instr = 1'b0;
  logic int_entry = 1'b0, mask_wr = 1'b0, pc_load = 1'b0;
  logic [2:0] wr_sel = 3'h0, rd_sel = 3'h0, alu_op = 3'h0;
  logic [7:0] wr_data = 8'h00, alu_a = 8'h00, alu_b = 8'h00, push_data = 8'h00;
  logic [1:0] int_priority_regs = 2'h0, mask_wr_val = 2'h0, stk_op = 2'h0;
  logic [15:0] pc_next_in = 16'h0000;
  logic [7:0] rd_data, pop_data, stk_wr_data, acc_q, idx_x_q, idx_y_q, condition_flags;
  logic stk_wr;
  logic [15:0] stk_addr, program_counter, stack_pointer;
  int error_cnt = 0;
  int total_checks = 0;

  ccr_core_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data), .alu_op(alu_op), .alu_a(alu_a),
    .alu_b(alu_b), .alu_wr_acc(alu_wr_acc), .shift_carry(shift_carry),
    .set_carry_instr(set_carry_instr), .clear_carry_instr(clear_carry_instr),
    .int_entry(int_entry), .int_priority_regs(int_priority_regs), .mask_wr(mask_wr),
    .mask_wr_val(mask_wr_val), .pc_load(pc_load), .pc_next_in(pc_next_in), .stk_op(stk_op),
    .push_data(push_data), .pop_data(pop_data), .stk_wr_data(stk_wr_data), .stk_wr(stk_wr),
    .stk_addr(stk_addr), .acc_q(acc_q), .idx_x_q(idx_x_q), .idx_y_q(idx_y_q),
    .program_counter(program_counter), .condition_flags(condition_flags),
    .stack_pointer(stack_pointer));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ============================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Lets one quiet edge pass, so that no strobe drops and rises at one instant.
  task automatic idle();
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : idle

  // One edge is taken, then all strobes drop at the following falling edge.
  task automatic step();
    @(posedge clk_sys);
    @(negedge clk_sys);
    wr_en = 1'b0;
    alu_op = CCR_OP_NONE;
    alu_wr_acc = 1'b0;
    set_carry_instr = 1'b0;
    clear_carry_instr = 1'b0;
    int_entry = 1'b0;
    mask_wr = 1'b0;
    pc_load = 1'b0;
    stk_op = CCR_STK_IDLE;
    wr_sel = CCR_SEL_NONE;
  endtask : step

  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    idle();
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    step();
  endtask : wr

  task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
    rd_sel = sel;
    step();
    chk("rd_data", {8'h00, rd_data}, {8'h00, exp});
  endtask : rd

  task automatic stk(input logic [1:0] op, input logic [7:0] d);
    idle();
    stk_op = op;
    push_data = d;
    step();
  endtask : stk

  // Only the flag bits named by msk are judged, the rest may legally vary.
  task automatic alu(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] res, input logic [7:0] msk, input logic [7:0] fl);
    idle();
    alu_op = op;
    alu_a = a;
    alu_b = b;
    alu_wr_acc = 1'b1;
    step();
    chk("acc_q", {8'h00, acc_q}, {8'h00, res});
    chk("flags", {8'h00, condition_flags & msk}, {8'h00, fl & msk});
  endtask : alu

  // ============================================================
  // Scenarios
  task automatic t_reset();
    chk("flags", {8'h00, condition_flags}, 16'h00e8);
    chk("sp", stack_pointer, 16'h01ff);
    chk("pc", program_counter, 16'h0000);
  endtask : t_reset

  task automatic t_alu();
    alu(CCR_OP_ADD, 8'h0f, 8'h01, 8'h10, 8'h17, 8'h10);
    alu(CCR_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h17, 8'h13);
    alu(CCR_OP_ADD, 8'h70, 8'h10, 8'h80, 8'h17, 8'h04);
    idle();
    set_carry_instr = 1'b1;
    clear_carry_instr = 1'b1;
    step();
    chk("carry", {15'h0000, condition_flags[FLAG_CARRY]}, 16'h0001);
    alu(CCR_OP_ADC, 8'h0e, 8'h01, 8'h10, 8'h17, 8'h10);
    alu(CCR_OP_LOGIC, 8'h80, 8'h00, 8'h80, 8'h06, 8'h04);
    shift_carry = 1'b1;
    alu(CCR_OP_SHIFT, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03);
    idle();
    clear_carry_instr = 1'b1;
    step();
    chk("carry", {15'h0000, condition_flags[FLAG_CARRY]}, 16'h0000);
    alu(CCR_OP_ARITH, 8'h90, 8'h80, 8'h10, 8'h07, 8'h01);
  endtask : t_alu

  task automatic t_mask();
    wr(CCR_SEL_FLAGS, 8'h00);
    chk("flags", {8'h00, condition_flags}, 16'h00c0);
    rd(CCR_SEL_FLAGS, 8'hc0);
    for (int i = 0; i < 4; i++) begin
      idle();
      mask_wr = 1'b1;
      mask_wr_val = i[1:0];
      step();
      chk("prio", {14'h0000, condition_flags[FLAG_PRIO_HI], condition_flags[FLAG_PRIO_LO]},
          {14'h0000, i[1:0]});
    end
    idle();
    int_entry = 1'b1;
    int_priority_regs = 2'h2;
    mask_wr = 1'b1;
    mask_wr_val = 2'h1;
    step();
    chk("prio", {14'h0000, condition_flags[FLAG_PRIO_HI], condition_flags[FLAG_PRIO_LO]},
        16'h0002);
  endtask : t_mask

  task automatic t_stack();
    wr(CCR_SEL_IDX_Y, 8'h5a);
    for (int i = 0; i < 5; i++) begin
      stk(CCR_STK_PUSH, 8'ha0 + i[7:0]);
      chk("stk_addr", stk_addr, 16'h01ff - i[15:0]);
      chk("stk_wr", {15'h0000, stk_wr}, 16'h0001);
      chk("stk_wr_data", {8'h00, stk_wr_data}, {8'h00, 8'ha0 + i[7:0]});
      if (i == 1) begin
        chk("sp", stack_pointer, 16'h01ff - {13'h0000, CALL_BYTES});
      end
    end
    chk("sp", stack_pointer, 16'h01ff - {13'h0000, INT_CTX_BYTES});
    chk("idx_y", {8'h00, idx_y_q}, 16'h005a);
    for (int i = 4; i >= 0; i--) begin
      stk(CCR_STK_POP, 8'h00);
      chk("pop_data", {8'h00, pop_data}, {8'h00, 8'ha0 + i[7:0]});
    end
    chk("sp", stack_pointer, 16'h01ff);
    stk(CCR_STK_POP, 8'h00);
    chk("sp", stack_pointer, 16'h0100);
    stk(CCR_STK_RESET, 8'h00);
    chk("sp", stack_pointer, 16'h01ff);
    wr(CCR_SEL_STACK_LOW, 8'h00);
    rd(CCR_SEL_STACK_LOW, 8'h00);
    stk(CCR_STK_PUSH, 8'h15);
    chk("sp", stack_pointer, 16'h01ff);
    idle();
    wr_sel = CCR_SEL_FLAGS;
    stk(CCR_STK_POP, 8'h00);
    chk("flags", {8'h00, condition_flags}, 16'h00d5);
  endtask : t_stack

  task automatic t_pc();
    idle();
    pc_load = 1'b1;
    pc_next_in = 16'h1234;
    step();
    chk("pc", program_counter, 16'h1234);
    wr(CCR_SEL_PC_LOW, 8'hcd);
    wr(CCR_SEL_PC_HIGH, 8'hab);
    chk("pc", program_counter, 16'habcd);
    rd(CCR_SEL_PC_HIGH, 8'hab);
    wr(CCR_SEL_ACC, 8'h3c);
    rd(CCR_SEL_ACC, 8'h3c);
    wr(CCR_SEL_IDX_X, 8'h77);
    chk("idx_x", {8'h00, idx_x_q}, 16'h0077);
    rd(CCR_SEL_IDX_X, 8'h77);
  endtask : t_pc

  initial begin
    #1000000;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_alu();
    t_mask();
    t_stack();
    t_pc();
    conclude();
  end
endmodule : tb
`default_nettype wire
